// ==== src/pfl_driver_enable.sv ====
// Driver enable generation, fault status latch and local interrupt
`timescale 1ns/1ns
// Summary of operation
// - Low-sides 1-6 need enable pin (3 and 6 unless config bit 15), both supplies good, clock if gated.
// - Low-side 7 same supplies and clock; enable pin dependence optional.
// - High-sides as low-sides, plus boost good when config bit 11 set.
// - Seven-bit status latches every condition that disabled drivers.
// - Status bit 6 marks missing clock, only when clock gating is on.
// - Status bit 5 is 1 unless pin went low since clear; resets 1.
// - Status bit 4 is a live copy of the enable pin.
// - Status bit 3 latches overtemperature, which never disables drivers.
// - Status bit 2 marks boost undervoltage that disabled high-sides.
// - Bit 1 latches logic supply low; bit 0 predrive low or ground loss.
// - A status write clears error bits only once their cause is gone.
// - With clear-on-read enabled, a status read also clears errors.
// - Local interrupt from five conditions, masked by config 9,8,7,6,10.
// - Interrupt forwarded to host pin by bit 0, cores by bits 1-4.
// - Return request on re-enable (bit 5 low) or status clear (high).
// - Config bit 12 picks boost divide by 32 (0) or by 4 (1).
// - Config bit 13 set frees low-side 7 from enable pin; resets 1.
// - Config bit 15 frees high-side 5, low-sides 3 and 6 from pin.
// - Bit 14 picks external supply; in bootstrap init inverse strap.
// - Strap latched at reset release, kept over register resets.
module pfl_driver_enable (
  // Clock and register reset
  input wire logic clk,
  input wire logic nrst,
  // Reset pins that latch the strap
  input wire logic power_on_reset_n,
  input wire logic pin_reset_n,
  // Debug strap pin
  input wire logic debug_strap_pin,
  output logic debug_strap_oe,
  // Monitored conditions from pins and comparators
  input wire pfl_pkg::pfl_async_t cond_pins,
  // Same domain status and settings
  input wire logic clock_present,
  input wire logic clock_loss_gate_en,
  input wire logic clear_on_read_en,
  input wire logic bootstrap_init,
  // Register port from the serial interface
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Driver enables
  output logic [6:0] low_side_enable,
  output logic [4:0] high_side_enable,
  // Interrupts
  output logic host_interrupt_pin_n,
  output logic [3:0] core_irq,
  output logic core_iret,
  // Analog settings
  output logic boost_divide_by_4,
  output logic predrive_ext_supply
);

  pfl_pkg::pfl_state_t s;
  pfl_pkg::pfl_state_t nx;
  logic base_ok;
  logic pin;
  logic clk_miss;
  logic stat_hit;
  logic clr;
  logic local_irq;

  // Sticky flag where a new event wins over a clear
  function automatic logic pfl_sticky(input logic set, input logic cur,
                                      input logic clr_i);
    return set | (cur & ~clr_i);
  endfunction : pfl_sticky

  // Next state
  always_comb begin
    nx = s;
    // Two stage synchronisers; only stage two is read
    nx.sync1 = cond_pins;
    nx.sync2 = s.sync1;
    nx.rst_s1 = {power_on_reset_n, pin_reset_n};
    nx.rst_s2 = s.rst_s1;
    nx.strap_s1 = debug_strap_pin;
    nx.strap_s2 = s.strap_s1;
    // Follow the strap while either reset is low, freeze on release
    if (s.rst_s2 != 2'h3) begin
      nx.strap = s.strap_s2;
    end
    pin = s.sync2.drv_pin;
    clk_miss = clock_loss_gate_en & ~clock_present;
    // Overtemperature deliberately absent from the enable terms
    base_ok = ~s.sync2.predrive_low & ~s.sync2.logic_low & ~clk_miss;
    // Low-side enables, index 0 is low-side one
    for (int i = 0; i < 6; i++) begin
      nx.ls[i] = base_ok & pin;
    end
    nx.ls[2] = base_ok & (pin | s.cfg[pfl_pkg::PFL_CFG_HS5_OVR]);
    nx.ls[5] = base_ok & (pin | s.cfg[pfl_pkg::PFL_CFG_HS5_OVR]);
    nx.ls[6] = base_ok & (pin | s.cfg[pfl_pkg::PFL_CFG_SEVENTH_LOW_OVERRIDE]);
    // High-side enables with optional boost disable
    for (int i = 0; i < 5; i++) begin
      nx.hs[i] = base_ok & pin & ~(s.sync2.boost_low
                 & s.cfg[pfl_pkg::PFL_CFG_BOOST_DIS]);
    end
    nx.hs[4] = base_ok & (pin | s.cfg[pfl_pkg::PFL_CFG_HS5_OVR])
               & ~(s.sync2.boost_low
               & s.cfg[pfl_pkg::PFL_CFG_BOOST_DIS]);
    // Register access decode
    stat_hit = reg_addr == pfl_pkg::PFL_STAT_ADDR;
    clr = stat_hit & (reg_wr | (reg_rd & clear_on_read_en));
    if (reg_wr && reg_addr == pfl_pkg::PFL_CFG_ADDR) begin
      nx.cfg = reg_wdata;
    end
    // Status latches; a live cause holds its bit through a clear
    nx.status[pfl_pkg::PFL_ST_CLK] = pfl_sticky(clk_miss,
      s.status[pfl_pkg::PFL_ST_CLK], clr);
    nx.status[pfl_pkg::PFL_ST_PIN_HELD] = ~pfl_sticky(~pin,
      ~s.status[pfl_pkg::PFL_ST_PIN_HELD], clr);
    nx.status[pfl_pkg::PFL_ST_PIN_NOW] = pin;
    nx.status[pfl_pkg::PFL_ST_OT] = pfl_sticky(s.sync2.over_temp,
      s.status[pfl_pkg::PFL_ST_OT], clr);
    nx.status[pfl_pkg::PFL_ST_BOOST] = pfl_sticky(s.sync2.boost_low
      & s.cfg[pfl_pkg::PFL_CFG_BOOST_DIS],
      s.status[pfl_pkg::PFL_ST_BOOST], clr);
    nx.status[pfl_pkg::PFL_ST_LOGIC] = pfl_sticky(s.sync2.logic_low,
      s.status[pfl_pkg::PFL_ST_LOGIC], clr);
    nx.status[pfl_pkg::PFL_ST_PRED] = pfl_sticky(s.sync2.predrive_low
      | s.sync2.gnd_loss, s.status[pfl_pkg::PFL_ST_PRED], clr);
    // Read data, registered; unmapped offsets read zero
    if (reg_rd) begin
      if (reg_addr == pfl_pkg::PFL_CFG_ADDR) begin
        nx.rdata = s.cfg;
      end else if (stat_hit) begin
        nx.rdata = {9'h000, s.status};
      end else begin
        nx.rdata = 16'h0000;
      end
    end
    // Local interrupt from live conditions, each masked
    local_irq = (~pin & s.cfg[pfl_pkg::PFL_CFG_PIN_IRQ])
      | (s.sync2.boost_low & s.cfg[pfl_pkg::PFL_CFG_BOOST_IRQ])
      | (s.sync2.logic_low & s.cfg[pfl_pkg::PFL_CFG_LOGIC_IRQ])
      | (s.sync2.predrive_low & s.cfg[pfl_pkg::PFL_CFG_PRED_IRQ])
      | (s.sync2.over_temp & s.cfg[pfl_pkg::PFL_CFG_OT_IRQ]);
    nx.irq_n = ~(local_irq & s.cfg[pfl_pkg::PFL_CFG_IRQ_HOST]);
    nx.core_irq = {4{local_irq}}
      & s.cfg[pfl_pkg::PFL_CFG_IRQ_CORE +: 4];
    // Return request; cores may ignore it in microcode
    if (s.cfg[pfl_pkg::PFL_CFG_IRET_SEL]) begin
      nx.iret = clr;
    end else begin
      nx.iret = nx.ls[0] & ~s.ls[0];
    end
    nx.boost_div = s.cfg[pfl_pkg::PFL_CFG_BOOST_DIV];
    nx.ext_supply = bootstrap_init ? ~s.strap
      : s.cfg[pfl_pkg::PFL_CFG_EXT_SUP];
  end

  // State register; synchronisers and strap survive register reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
      s.cfg <= pfl_pkg::PFL_CFG_RST;
      s.status <= pfl_pkg::PFL_STAT_RST;
      s.irq_n <= 1'b1;
      s.sync1 <= nx.sync1;
      s.sync2 <= nx.sync2;
      s.rst_s1 <= nx.rst_s1;
      s.rst_s2 <= nx.rst_s2;
      s.strap_s1 <= nx.strap_s1;
      s.strap_s2 <= nx.strap_s2;
      s.strap <= nx.strap;
    end else begin
      s <= nx;
    end
  end

  // Outputs straight from state; strap output enable tied low
  assign reg_rdata = s.rdata;
  assign low_side_enable = s.ls;
  assign high_side_enable = s.hs;
  assign host_interrupt_pin_n = s.irq_n;
  assign core_irq = s.core_irq;
  assign core_iret = s.iret;
  assign boost_divide_by_4 = s.boost_div;
  assign predrive_ext_supply = s.ext_supply;
  assign debug_strap_oe = 1'b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_reenable;
    !low_side_enable[0] ##1 low_side_enable[0];
  endsequence

  property p_ls_needs_pin;
    $past(!s.sync2.drv_pin) |-> !low_side_enable[0];
  endproperty
  a_ls_needs_pin: assert property (p_ls_needs_pin)
    else $error("low side on with enable pin low");

  property p_ls7_pin;
    $past(!s.sync2.drv_pin && !s.cfg[13]) |-> !low_side_enable[6];
  endproperty
  a_ls7_pin: assert property (p_ls7_pin)
    else $error("low side seven ignored enable pin");

  property p_hs_boost;
    $past(s.sync2.boost_low && s.cfg[11]) |-> high_side_enable == 5'h00;
  endproperty
  a_hs_boost: assert property (p_hs_boost)
    else $error("high side on during boost undervoltage");

  property p_clk_flag;
    $past(clock_loss_gate_en && !clock_present) |-> s.status[6];
  endproperty
  a_clk_flag: assert property (p_clk_flag)
    else $error("missing clock not latched");

  property p_pin_held;
    $past(!s.sync2.drv_pin) |-> !s.status[5];
  endproperty
  a_pin_held: assert property (p_pin_held)
    else $error("enable pin low not latched");

  property p_pin_now;
    $past(nrst) |-> s.status[4] == $past(s.sync2.drv_pin);
  endproperty
  a_pin_now: assert property (p_pin_now)
    else $error("live pin copy wrong");

  property p_ot_no_disable;
    $past(nrst && s.sync2.drv_pin && !s.sync2.predrive_low
      && !s.sync2.logic_low && !(clock_loss_gate_en && !clock_present))
      |-> low_side_enable[0];
  endproperty
  a_ot_no_disable: assert property (p_ot_no_disable)
    else $error("low side off without a disabling cause");

  property p_hold_on_clear;
    $past(clr && s.sync2.logic_low) |-> s.status[1];
  endproperty
  a_hold_on_clear: assert property (p_hold_on_clear)
    else $error("error bit cleared while cause present");

  property p_cor;
    $past(reg_rd && stat_hit && clear_on_read_en && !s.sync2.logic_low)
      |-> !s.status[1];
  endproperty
  a_cor: assert property (p_cor)
    else $error("clear on read did not clear");

  property p_host_irq;
    !host_interrupt_pin_n |-> $past(s.cfg[0] && local_irq);
  endproperty
  a_host_irq: assert property (p_host_irq)
    else $error("host interrupt without masked cause");

  property p_iret_reenable;
    (s_reenable ##0 !$past(s.cfg[5])) |-> core_iret;
  endproperty
  a_iret_reenable: assert property (p_iret_reenable)
    else $error("no return request on re-enable");

  property p_ext_supply;
    $past(nrst) |-> predrive_ext_supply
      == $past(bootstrap_init ? ~s.strap : s.cfg[14]);
  endproperty
  a_ext_supply: assert property (p_ext_supply)
    else $error("supply select wrong");

  // Flags, forwarding and strap; strap check also runs through nrst
  property p_boost_flag;
    $past(nrst && s.sync2.boost_low && s.cfg[pfl_pkg::PFL_CFG_BOOST_DIS])
      |-> s.status[pfl_pkg::PFL_ST_BOOST];
  endproperty
  a_boost_flag: assert property (p_boost_flag)
    else $error("boost undervoltage not latched");

  property p_boost_gated;
    $past(nrst && !s.cfg[pfl_pkg::PFL_CFG_BOOST_DIS]
      && !s.status[pfl_pkg::PFL_ST_BOOST])
      |-> !s.status[pfl_pkg::PFL_ST_BOOST];
  endproperty
  a_boost_gated: assert property (p_boost_gated)
    else $error("boost flag set while its disable is off");

  property p_core_fwd;
    $past(nrst) |-> core_irq == ({4{$past(local_irq)}}
      & $past(s.cfg[pfl_pkg::PFL_CFG_IRQ_CORE +: 4]));
  endproperty
  a_core_fwd: assert property (p_core_fwd)
    else $error("core interrupt forward wrong");

  property p_boost_div;
    $past(nrst) |-> boost_divide_by_4
      == $past(s.cfg[pfl_pkg::PFL_CFG_BOOST_DIV]);
  endproperty
  a_boost_div: assert property (p_boost_div)
    else $error("boost divider select wrong");

  property p_strap_hold;
    disable iff (1'b0) $past(s.rst_s2) == 2'h3 |-> $stable(s.strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("latched strap changed after reset release");

  property p_iret_clear;
    $past(nrst && s.cfg[pfl_pkg::PFL_CFG_IRET_SEL] && clr) |-> core_iret;
  endproperty
  a_iret_clear: assert property (p_iret_clear)
    else $error("no return request on status clear");

  property p_ovr_group;
    $past(nrst && s.cfg[pfl_pkg::PFL_CFG_HS5_OVR] && !s.sync2.predrive_low
      && !s.sync2.logic_low && !clk_miss && !(s.sync2.boost_low
      && s.cfg[pfl_pkg::PFL_CFG_BOOST_DIS]))
      |-> low_side_enable[2] && low_side_enable[5] && high_side_enable[4];
  endproperty
  a_ovr_group: assert property (p_ovr_group)
    else $error("override group followed the enable pin");

endmodule : pfl_driver_enable

// ==== src/pfl_pkg.sv ====
// Package for the predriver enable and fault latch block
package pfl_pkg;
  // Register offsets on the internal register port
  localparam logic [9:0] PFL_CFG_ADDR = 10'h1C5;
  localparam logic [9:0] PFL_STAT_ADDR = 10'h1D2;
  // Values after reset
  localparam logic [15:0] PFL_CFG_RST = 16'h6000;
  localparam logic [6:0] PFL_STAT_RST = 7'h21;
  // Configuration field positions
  localparam int PFL_CFG_IRQ_HOST = 0;
  localparam int PFL_CFG_IRQ_CORE = 1;
  localparam int PFL_CFG_IRET_SEL = 5;
  localparam int PFL_CFG_PRED_IRQ = 6;
  localparam int PFL_CFG_LOGIC_IRQ = 7;
  localparam int PFL_CFG_BOOST_IRQ = 8;
  localparam int PFL_CFG_PIN_IRQ = 9;
  localparam int PFL_CFG_OT_IRQ = 10;
  localparam int PFL_CFG_BOOST_DIS = 11;
  localparam int PFL_CFG_BOOST_DIV = 12;
  localparam int PFL_CFG_SEVENTH_LOW_OVERRIDE = 13;
  localparam int PFL_CFG_EXT_SUP = 14;
  localparam int PFL_CFG_HS5_OVR = 15;
  // Status field positions
  localparam int PFL_ST_PRED = 0;
  localparam int PFL_ST_LOGIC = 1;
  localparam int PFL_ST_BOOST = 2;
  localparam int PFL_ST_OT = 3;
  localparam int PFL_ST_PIN_NOW = 4;
  localparam int PFL_ST_PIN_HELD = 5;
  localparam int PFL_ST_CLK = 6;

  // Pin level inputs that cross into the clock domain
  typedef struct packed {
    logic gnd_loss;
    logic over_temp;
    logic boost_low;
    logic logic_low;
    logic predrive_low;
    logic drv_pin;
  } pfl_async_t;

  // Whole state of the block
  typedef struct packed {
    pfl_async_t sync1;
    pfl_async_t sync2;
    logic [1:0] rst_s1;
    logic [1:0] rst_s2;
    logic strap_s1;
    logic strap_s2;
    logic strap;
    logic [15:0] cfg;
    logic [6:0] status;
    logic [15:0] rdata;
    logic [6:0] ls;
    logic [4:0] hs;
    logic irq_n;
    logic [3:0] core_irq;
    logic iret;
    logic boost_div;
    logic ext_supply;
  } pfl_state_t;
endpackage : pfl_pkg

// ==== dv/pfl_core_model.sv ====
// Microcore side model that counts return-from-interrupt requests
`timescale 1ns/1ns
module pfl_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Return request from the block
  input wire logic core_iret,
  // Requests seen by the cores
  output int iret_seen
);
  // Count every pulse; microcode decides later which ones to drop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      iret_seen <= 0;
    end else if (core_iret) begin
      iret_seen <= iret_seen + 1;
    end
  end
endmodule : pfl_core_model

// ==== dv/pfl_driver_enable_bench.sv ====
// Self-checking bench for the driver enable and fault latch
`timescale 1ns/1ns
module pfl_driver_enable_bench;
  localparam logic [9:0] a_cfg = pfl_pkg::PFL_CFG_ADDR;
  localparam logic [9:0] a_st = pfl_pkg::PFL_STAT_ADDR;
  logic clk, nrst, por_n, prst_n, dbg, clk_ok, gate_en, cor_en, boot;
  logic wr, rd, irq_n, iret, div4, ext, oe;
  pfl_pkg::pfl_async_t cond;
  logic [9:0] addr;
  logic [15:0] wdata, rdata;
  logic [6:0] ls;
  logic [4:0] hs;
  logic [3:0] cirq;
  int n_fail, compares, cyc, iret_seen, n;

  pfl_driver_enable dut_u (.clk(clk), .nrst(nrst),
    .power_on_reset_n(por_n), .pin_reset_n(prst_n),
    .debug_strap_pin(dbg), .debug_strap_oe(oe), .cond_pins(cond),
    .clock_present(clk_ok), .clock_loss_gate_en(gate_en),
    .clear_on_read_en(cor_en), .bootstrap_init(boot),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .low_side_enable(ls), .high_side_enable(hs),
    .host_interrupt_pin_n(irq_n), .core_irq(cirq), .core_iret(iret),
    .boost_divide_by_4(div4), .predrive_ext_supply(ext));
  pfl_core_model core_u (.clk(clk), .nrst(nrst), .core_iret(iret),
    .iret_seen(iret_seen));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Strobes last one edge, so back to back calls never collide
  task automatic wreg(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rreg

  // Pins pass two sync stages and an output stage
  task automatic pins(input pfl_pkg::pfl_async_t v);
    @(posedge clk);
    cond <= v;
    tick(4);
  endtask : pins

  task automatic en(input logic [6:0] l, input logic [4:0] h);
    chk({9'h000, ls}, {9'h000, l});
    chk({11'h000, hs}, {11'h000, h});
  endtask : en

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    {nrst, por_n, wr, rd, gate_en, cor_en, boot} = 7'h00;
    {prst_n, dbg, clk_ok} = 3'h7;
    cond = 6'h01;
    addr = 10'h000;
    wdata = 16'h0000;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    tick(4);
    en(7'h7F, 5'h1F);
    chk({14'h0000, div4, oe}, 16'h0000);
    rreg(a_cfg, 16'h6000);
    rreg(a_st, 16'h0031);
    rreg(10'h1C6, 16'h0000);
    wreg(a_st, 16'h0000);
    rreg(a_st, 16'h0030);
    wreg(a_cfg, 16'h2201);
    pins(6'h00);
    en(7'h40, 5'h00);
    chk({15'h0000, irq_n}, 16'h0000);
    rreg(a_st, 16'h0000);
    wreg(a_cfg, 16'hA000);
    tick(2);
    en(7'h64, 5'h10);
    chk({15'h0000, irq_n}, 16'h0001);
    n = iret_seen;
    pins(6'h01);
    chk(16'(iret_seen - n), 16'h0001);
    rreg(a_st, 16'h0010);
    wreg(a_st, 16'h0000);
    rreg(a_st, 16'h0030);
    // Overtemperature with every core forward and clear-driven return
    wreg(a_cfg, 16'h04FE);
    pins(6'h11);
    en(7'h7F, 5'h1F);
    chk({12'h000, cirq}, 16'h000F);
    chk({15'h0000, irq_n}, 16'h0001);
    pins(6'h01);
    rreg(a_st, 16'h0038);
    n = iret_seen;
    wreg(a_st, 16'h0000);
    tick(2);
    chk(16'(iret_seen - n), 16'h0001);
    @(posedge clk);
    cor_en <= 1'b1;
    pins(6'h05);
    en(7'h00, 5'h00);
    chk({12'h000, cirq}, 16'h000F);
    pins(6'h01);
    rreg(a_st, 16'h0032);
    rreg(a_st, 16'h0030);
    pins(6'h03);
    chk({12'h000, cirq}, 16'h000F);
    wreg(a_st, 16'h0000);
    rreg(a_st, 16'h0031);
    pins(6'h21);
    rreg(a_st, 16'h0031);
    pins(6'h01);
    rreg(a_st, 16'h0031);
    rreg(a_st, 16'h0030);
    // Clock loss, gated and ungated
    @(posedge clk);
    gate_en <= 1'b1;
    clk_ok <= 1'b0;
    tick(1);
    en(7'h00, 5'h00);
    @(posedge clk);
    clk_ok <= 1'b1;
    tick(2);
    rreg(a_st, 16'h0070);
    @(posedge clk);
    gate_en <= 1'b0;
    clk_ok <= 1'b0;
    tick(2);
    en(7'h7F, 5'h1F);
    rreg(a_st, 16'h0030);
    @(posedge clk);
    clk_ok <= 1'b1;
    // Boost undervoltage drops only high-sides
    wreg(a_cfg, 16'h1901);
    pins(6'h09);
    en(7'h7F, 5'h00);
    chk({15'h0000, div4}, 16'h0001);
    chk({15'h0000, irq_n}, 16'h0000);
    pins(6'h01);
    rreg(a_st, 16'h0034);
    // Boost disable off: no drop, no flag, no interrupt
    wreg(a_cfg, 16'h0000);
    pins(6'h09);
    en(7'h7F, 5'h1F);
    chk({15'h0000, irq_n}, 16'h0001);
    pins(6'h01);
    rreg(a_st, 16'h0030);
    // Strap bypass survives a register reset
    wreg(a_cfg, 16'h4000);
    tick(2);
    chk({15'h0000, ext}, 16'h0001);
    @(posedge clk);
    boot <= 1'b1;
    tick(2);
    chk({15'h0000, ext}, 16'h0000);
    @(posedge clk);
    nrst <= 1'b0;
    dbg <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tick(3);
    chk({15'h0000, ext}, 16'h0000);
    rreg(a_cfg, 16'h6000);
    test_done();
  end
endmodule : pfl_driver_enable_bench
